// [sim/lfs_host_model.sv]
// host side of the shared fault line: pull-up plus another party pulling low
module lfs_host_model (
   input wire logic i_sys_clk,
   input wire logic i_dut_oe,
   input wire logic i_dut_o,
   input wire logic i_pull_req,
   output logic o_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pull_r = 1'b0;
   // other party pulls the line low on request, clock aligned
   always_ff @(posedge i_sys_clk) begin
      pull_r <= i_pull_req;
   end
   // wired-and with pull-up: low while any party drives low
   assign o_line = (i_dut_oe ? i_dut_o : 1'b1) & ~pull_r;
endmodule // lfs_host_model

// [sim/lfs_supervisor_tb.sv]
// self-checking bench for the led fault supervisor
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, (a), (b)); end end
module lfs_supervisor_tb import lfs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 100; // cycles per ms tick with 4 us per ms
   logic clk = 1'b0, rst = 1'b1, overcurrent_trip = 1'b0, sdiff = 1'b0, clamp = 1'b0, vlow = 1'b0;
   logic vhigh = 1'b1, boot = 1'b0, lock = 1'b0, pwm = 1'b0, hs_cmd = 1'b0, pull = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic [3:0] sel = 4'hf;
   logic oe, fo, hs_en, str_en, irq, ack;
   logic [31:0] odat;
   wire logic line_lvl;
   int error_cnt = 0;
   int n_checks = 0;
   ////////////////////////////////////////////////////////////////////////
   // design and far side of the fault line
   lfs_supervisor #(.P_US_PER_MS(4)) dut (.i_sys_clk(clk), .i_reset(rst),
      .i_overcurrent_trip(overcurrent_trip), .i_sense_diff_high(sdiff), .i_error_amp_output_clamp(clamp),
      .i_out_below_short(vlow), .i_out_above_recover(vhigh), .i_boot_diff_high(boot),
      .i_supply_lockout(lock), .i_pwm_dim(pwm), .i_hs_command(hs_cmd),
      .i_fault_line_n_i(line_lvl), .o_fault_line_n_o(fo), .o_fault_line_n_oe(oe),
      .o_hs_enable(hs_en), .o_string_enable(str_en), .o_irq(irq), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
      .o_wb_dat(odat), .o_wb_ack(ack));
   lfs_host_model host (.i_sys_clk(clk), .i_dut_oe(oe), .i_dut_o(fo), .i_pull_req(pull),
      .o_line(line_lvl));
   // clock
   initial begin
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic report_and_stop();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk);
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return oe;
         1: return hs_en;
         default: return str_en;
      endcase
   endfunction
   task automatic wait_for(input int w, input logic v, input int max);
      int i;
      for (i = 0; i < max && pick(w) !== v; i++) @(posedge clk);
      `CHK(pick(w), v)
   endtask
   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      `CHK(ack, 1'b1)
      rdat = odat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(rdat, e)
   endtask
   task automatic clr();
      wb(1'b1, ADR_STAT, 32'h7f);
   endtask
   // line still held 8.5 ms after the cause went, released by 11.5 ms
   task automatic rec_chk();
      cyc_n(8 * MS + 50);
      `CHK(oe, 1'b1)
      wait_for(0, 1'b0, 3 * MS);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         pwm <= 1'b1;
         cyc_n(10);
         pwm <= 1'b0;
         cyc_n(10);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      `CHK({oe, hs_en, str_en, irq}, 4'b0110)
      wb(1'b1, ADR_CTRL, 32'h0);
      `CHK({hs_en, str_en}, 2'b00)
      wb(1'b1, ADR_CTRL, 32'h2);
      `CHK({hs_en, str_en}, 2'b11)
      rd_chk(ADR_CTRL, 32'h2);
      rd_chk(ADR_MASK, 32'h0);
      rd_chk(ADR_STAT, 32'h0);
      wb(1'b1, 8'h10, 32'hff);
      rd_chk(8'h10, 32'h0);
   endtask
   task automatic t_ocp();
      wb(1'b1, ADR_MASK, 32'h01);
      overcurrent_trip <= 1'b1;
      cyc_n(9);
      `CHK({hs_en, oe, irq}, 3'b011)
      cyc_n(50);
      overcurrent_trip <= 1'b0;
      rec_chk();
      wait_for(1, 1'b1, 3 * MS);
      rd_chk(ADR_STAT, 32'h01);
      clr();
      `CHK(irq, 1'b0)
      wb(1'b1, ADR_MASK, 32'h0);
   endtask
   task automatic t_sopen();
      sdiff <= 1'b1;
      cyc_n(10);
      `CHK({hs_en, str_en}, 2'b00)
      cyc_n(290);
      sdiff <= 1'b0;
      cyc_n(10);
      `CHK(oe, 1'b0)
      wait_for(1, 1'b1, 12 * MS);
      sdiff <= 1'b1;
      cyc_n(450);
      `CHK({oe, str_en}, 2'b00)
      wait_for(0, 1'b1, MS);
      sdiff <= 1'b0;
      rec_chk();
      wait_for(1, 1'b1, 3 * MS);
      clr();
   endtask
   task automatic t_bopen();
      boot <= 1'b1;
      cyc_n(50);
      `CHK({oe, hs_en}, 2'b01)
      hs_cmd <= 1'b1;
      cyc_n(9);
      `CHK({oe, hs_en}, 2'b10)
      boot <= 1'b0;
      rec_chk();
      wait_for(1, 1'b1, 3 * MS);
      hs_cmd <= 1'b0;
      clr();
   endtask
   task automatic t_bshort();
      lock <= 1'b1;
      cyc_n(8);
      `CHK(hs_en, 1'b0)
      cyc_n(8 * MS + 40);
      `CHK(oe, 1'b0)
      wait_for(0, 1'b1, 3 * MS);
      lock <= 1'b0;
      rec_chk();
      `CHK(hs_en, 1'b1)
      clr();
   endtask
   task automatic t_lopen();
      clamp <= 1'b1;
      cyc_n(8 * MS + 50);
      `CHK(oe, 1'b0)
      wait_for(0, 1'b1, 3 * MS);
      `CHK(str_en, 1'b0)
      clamp <= 1'b0;
      rec_chk();
      wait_for(2, 1'b1, 20);
      clr();
   endtask
   task automatic t_lshort();
      vhigh <= 1'b0;
      vlow <= 1'b1;
      cyc_n(8 * MS + 50);
      `CHK(oe, 1'b0)
      wait_for(0, 1'b1, 3 * MS);
      `CHK(str_en, 1'b0)
      vlow <= 1'b0;
      vhigh <= 1'b1;
      cyc_n(18 * MS + 50);
      `CHK(oe, 1'b1)
      wait_for(0, 1'b0, 4 * MS);
      clr();
   endtask
   // dimming: count restarts when the condition drops, then 16 edges
   task automatic t_dim();
      wb(1'b1, ADR_CTRL, 32'h3);
      clamp <= 1'b1;
      cyc_n(600);
      pulses(8);
      clamp <= 1'b0;
      cyc_n(20);
      clamp <= 1'b1;
      cyc_n(600);
      pulses(15);
      `CHK(oe, 1'b0)
      pulses(1);
      wait_for(0, 1'b1, 20);
      clamp <= 1'b0;
      rec_chk();
      wb(1'b1, ADR_CTRL, 32'h2);
      clr();
   endtask
   task automatic t_ext();
      pull <= 1'b1;
      cyc_n(20);
      `CHK({hs_en, str_en}, 2'b00)
      rd_chk(ADR_STAT, 32'h40);
      rd_chk(ADR_STATE, 32'h1c0);
      pull <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      cyc_n(8);
      rst <= 1'b0;
      cyc_n(4);
      t_reset();
      t_ocp();
      t_sopen();
      t_bopen();
      t_bshort();
      t_lopen();
      t_lshort();
      t_dim();
      t_ext();
      report_and_stop();
   end
   // watchdog, between two and three times the expected run
   initial begin
      cyc_n(40000);
      error_cnt++;
      report_and_stop();
   end
endmodule // lfs_supervisor_tb

// [src/lfs_fault_chan.sv]
// one fault source: qualify, report, recover and retry hold-off
module lfs_fault_chan import lfs_pkg::*; #(
   parameter bit USE_DEGL = 1'b0,
   parameter bit USE_QUAL = 1'b0,
   parameter bit USE_RECQ = 1'b0,
   parameter bit USE_RETRY = 1'b1,
   parameter int DEGL_US = DEGLITCH_US,
   parameter int PWM_N = PWM_QUAL_CYC,
   parameter int QUAL_N = QUAL_MS,
   parameter int REC_N = REC_MS,
   parameter int RETRY_N = RETRY_MS
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_us_tick,
   input wire logic i_ms_tick,
   input wire logic i_pwm_edge,
   input wire logic i_dim_mode,
   input wire logic i_cond,
   input wire logic i_clear,
   output logic o_report,
   output logic o_trip
);

   // counters are eight bits wide
   if (DEGL_US < 1 || DEGL_US > 255 || PWM_N < 1 || PWM_N > 255 ||
       QUAL_N < 1 || QUAL_N > 255 || REC_N < 1 || REC_N > 255 ||
       RETRY_N < 1 || RETRY_N > 255) begin : g_chk
      $error("lfs_fault_chan: count out of range");
   end

   lfs_chan_state_t state_r;
   logic [7:0] cnt_r;
   logic [7:0] retry_r;
   logic us_done;
   logic qual_step;
   logic qual_done;
   logic ms_done;

   // terminal counts of each timing phase
   assign us_done = i_us_tick && (cnt_r == 8'(DEGL_US - 1));
   assign qual_step = i_dim_mode ? i_pwm_edge : i_ms_tick;
   assign qual_done = qual_step &&
      (cnt_r == (i_dim_mode ? 8'(PWM_N - 1) : 8'(QUAL_N - 1)));
   assign ms_done = i_ms_tick && (cnt_r == 8'(REC_N - 1));

   // qualify and recovery sequence
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_r <= CH_IDLE;
         cnt_r <= 8'h00;
      end else begin
         case (state_r)
            CH_IDLE: begin
               cnt_r <= 8'h00;
               if (i_cond) begin
                  if (USE_DEGL && (!USE_QUAL || i_dim_mode)) begin
                     state_r <= CH_DEGL;
                  end else if (USE_QUAL) begin
                     state_r <= CH_QUAL;
                  end else begin
                     state_r <= CH_REPORT;
                  end
               end
            end
            CH_DEGL: begin
               if (!i_cond) begin
                  state_r <= CH_IDLE;
               end else if (us_done) begin
                  cnt_r <= 8'h00;
                  state_r <= USE_QUAL ? CH_QUAL : CH_REPORT;
               end else if (i_us_tick) begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            CH_QUAL: begin
               if (!i_cond) begin
                  state_r <= CH_IDLE;
               end else if (qual_done) begin
                  cnt_r <= 8'h00;
                  state_r <= CH_REPORT;
               end else if (qual_step) begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            CH_REPORT: begin
               cnt_r <= 8'h00;
               if (i_clear) begin
                  state_r <= USE_RECQ ? CH_RECQ : CH_RECOVER;
               end
            end
            CH_RECQ: begin
               if (!i_clear) begin
                  state_r <= CH_REPORT;
               end else if (ms_done) begin
                  cnt_r <= 8'h00;
                  state_r <= CH_RECOVER;
               end else if (i_ms_tick) begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            CH_RECOVER: begin
               if (!i_clear) begin
                  cnt_r <= 8'h00;
                  state_r <= CH_REPORT;
               end else if (ms_done) begin
                  state_r <= CH_IDLE;
               end else if (i_ms_tick) begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            default: begin
               state_r <= CH_IDLE;
               cnt_r <= 8'h00;
            end
         endcase
      end
   end

   // retry hold-off reloads while the condition persists
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         retry_r <= 8'h00;
      end else if (i_cond) begin
         retry_r <= 8'(RETRY_N);
      end else if (i_ms_tick && retry_r != 8'h00) begin
         retry_r <= retry_r - 8'h01;
      end
   end

   assign o_report = (state_r == CH_REPORT) || (state_r == CH_RECQ) ||
      (state_r == CH_RECOVER);
   assign o_trip = i_cond || (USE_RETRY && retry_r != 8'h00);

endmodule // lfs_fault_chan

// [src/lfs_pkg.sv]
// constants, register map and types shared by the led fault supervisor
package lfs_pkg;

   // clock and timebase
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int US_PER_SEC = 1_000_000;
   localparam int CYC_PER_US = CLK_HZ / US_PER_SEC;
   localparam int US_PER_MS = 1000;

   // fault timing, each in its own unit
   localparam int RETRY_MS = 10;
   localparam int DEGLITCH_US = 20;
   localparam int PWM_QUAL_CYC = 16;
   localparam int QUAL_MS = 10;
   localparam int REC_MS = 10;

   // register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_MASK = 8'h08;
   localparam logic [7:0] ADR_STATE = 8'h0c;

   // control fields and reset values
   localparam int CTRL_DIM_BIT = 0;
   localparam int CTRL_EN_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h2;
   localparam logic [6:0] MASK_RST = 7'h00;

   // event and channel positions
   localparam int EV_OCP = 0;
   localparam int EV_SOPEN = 1;
   localparam int EV_LOPEN = 2;
   localparam int EV_LSHORT = 3;
   localparam int EV_BOPEN = 4;
   localparam int EV_BSHORT = 5;
   localparam int EV_EXT = 6;
   localparam int NUM_CH = 6;
   localparam int NUM_EV = 7;

   // synchronised pin positions
   localparam int IN_OCP = 0;
   localparam int IN_SDIFF = 1;
   localparam int IN_CLAMP = 2;
   localparam int IN_VLOW = 3;
   localparam int IN_VHIGH = 4;
   localparam int IN_BOOT = 5;
   localparam int IN_LOCK = 6;
   localparam int IN_PWM = 7;
   localparam int IN_FLT = 8;
   localparam int NUM_IN = 9;
   localparam logic [8:0] IN_RST = 9'h100;

   // per channel state
   typedef enum logic [2:0] {
      CH_IDLE = 3'b000,
      CH_DEGL = 3'b001,
      CH_QUAL = 3'b010,
      CH_REPORT = 3'b011,
      CH_RECQ = 3'b100,
      CH_RECOVER = 3'b101
   } lfs_chan_state_t;

endpackage

// [src/lfs_supervisor.sv]
// led driver fault supervisor: pin sync, timebase, channels, fault line, wishbone
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
module lfs_supervisor import lfs_pkg::*; #(
   parameter int P_US_PER_MS = US_PER_MS
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_overcurrent_trip,
   input wire logic i_sense_diff_high,
   input wire logic i_error_amp_output_clamp,
   input wire logic i_out_below_short,
   input wire logic i_out_above_recover,
   input wire logic i_boot_diff_high,
   input wire logic i_supply_lockout,
   input wire logic i_pwm_dim,
   input wire logic i_hs_command,
   input wire logic i_fault_line_n_i,
   output logic o_fault_line_n_o,
   output logic o_fault_line_n_oe,
   output logic o_hs_enable,
   output logic o_string_enable,
   output logic o_irq,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack
);

   if (P_US_PER_MS < 2 || P_US_PER_MS > 65535) begin : g_chk
      $error("lfs_supervisor: P_US_PER_MS out of range");
   end

   localparam int USW = $clog2(CYC_PER_US);
   localparam int MSW = $clog2(P_US_PER_MS);
   // channel options, one bit per channel
   localparam logic [5:0] DEGL_SET = 6'h0e;
   localparam logic [5:0] QUAL_SET = 6'h2c;
   localparam logic [5:0] RECQ_SET = 6'h08;
   localparam logic [5:0] RETRY_SET = 6'h13;
   localparam int DEGL_MIN = (DEGLITCH_US - 1) * CYC_PER_US;

   logic [NUM_IN-1:0] pins;
   logic [NUM_IN-1:0] s1_r;
   logic [NUM_IN-1:0] s2_r;
   logic [NUM_IN-1:0] s3_r;
   logic [NUM_IN-1:0] in_q_r;
   logic [USW-1:0] us_div_r;
   logic [MSW-1:0] ms_div_r;
   logic us_tick;
   logic ms_tick;
   logic pwm_d_r;
   logic pwm_edge;
   logic [NUM_CH-1:0] cond;
   logic [NUM_CH-1:0] clear;
   logic [NUM_CH-1:0] rep;
   logic [NUM_CH-1:0] trip;
   logic [NUM_CH-1:0] rep_d_r;
   logic drive_r;
   logic [3:0] drv_hist_r;
   logic ext_low;
   logic ext_d_r;
   logic hs_off;
   logic str_off;
   logic [1:0] ctrl_r;
   logic [NUM_EV-1:0] stat_r;
   logic [NUM_EV-1:0] mask_r;
   logic [NUM_EV-1:0] ev;
   logic wb_req;
   logic wb_wr;
   logic [31:0] rd_nxt;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers, three flops, change taken when two agree
   assign pins = {i_fault_line_n_i, i_pwm_dim, i_supply_lockout,
      i_boot_diff_high, i_out_above_recover, i_out_below_short,
      i_error_amp_output_clamp, i_sense_diff_high, i_overcurrent_trip};

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         s1_r <= IN_RST;
         s2_r <= IN_RST;
         s3_r <= IN_RST;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   for (genvar g = 0; g < NUM_IN; g++) begin : g_sync
      always_ff @(posedge i_sys_clk) begin
         if (i_reset) begin
            in_q_r[g] <= IN_RST[g];
         end else if (s2_r[g] == s3_r[g]) begin
            in_q_r[g] <= s3_r[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // microsecond and millisecond enables
   assign us_tick = (us_div_r == USW'(CYC_PER_US - 1));
   assign ms_tick = us_tick && (ms_div_r == MSW'(P_US_PER_MS - 1));

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         us_div_r <= '0;
         ms_div_r <= '0;
      end else begin
         us_div_r <= us_tick ? '0 : us_div_r + USW'(1);
         if (ms_tick) begin
            ms_div_r <= '0;
         end else if (us_tick) begin
            ms_div_r <= ms_div_r + MSW'(1);
         end
      end
   end

   // dimming cycle edge
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         pwm_d_r <= 1'b0;
      end else begin
         pwm_d_r <= in_q_r[IN_PWM];
      end
   end
   assign pwm_edge = in_q_r[IN_PWM] && !pwm_d_r;

   ////////////////////////////////////////////////////////////////////
   // fault sources: detect and clear conditions
   always_comb begin
      cond[EV_OCP] = in_q_r[IN_OCP];
      clear[EV_OCP] = !in_q_r[IN_OCP];
      cond[EV_SOPEN] = in_q_r[IN_SDIFF];
      clear[EV_SOPEN] = !in_q_r[IN_SDIFF];
      cond[EV_LOPEN] = in_q_r[IN_CLAMP];
      clear[EV_LOPEN] = !in_q_r[IN_CLAMP];
      cond[EV_LSHORT] = in_q_r[IN_VLOW];
      clear[EV_LSHORT] = in_q_r[IN_VHIGH];
      cond[EV_BOPEN] = i_hs_command && in_q_r[IN_BOOT];
      clear[EV_BOPEN] = !in_q_r[IN_BOOT];
      cond[EV_BSHORT] = in_q_r[IN_LOCK];
      clear[EV_BSHORT] = !in_q_r[IN_LOCK];
   end

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      lfs_fault_chan #(
         .USE_DEGL(DEGL_SET[c]),
         .USE_QUAL(QUAL_SET[c]),
         .USE_RECQ(RECQ_SET[c]),
         .USE_RETRY(RETRY_SET[c])
      ) u_chan (
         .i_sys_clk(i_sys_clk),
         .i_reset(i_reset),
         .i_us_tick(us_tick),
         .i_ms_tick(ms_tick),
         .i_pwm_edge(pwm_edge),
         .i_dim_mode(ctrl_r[CTRL_DIM_BIT]),
         .i_cond(cond[c]),
         .i_clear(clear[c]),
         .o_report(rep[c]),
         .o_trip(trip[c])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // shared fault line and external pull-down
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         drive_r <= 1'b0;
         drv_hist_r <= 4'h0;
      end else begin
         drive_r <= |rep;
         drv_hist_r <= {drv_hist_r[2:0], drive_r};
      end
   end
   assign o_fault_line_n_o = 1'b0;
   assign o_fault_line_n_oe = drive_r;
   // ignore our own release until the sync chain settles
   assign ext_low = !in_q_r[IN_FLT] && !drive_r && !(|drv_hist_r);

   // switch and string gating
   assign hs_off = trip[EV_OCP] || trip[EV_SOPEN] || trip[EV_BOPEN] ||
      trip[EV_BSHORT] || ext_low || !ctrl_r[CTRL_EN_BIT];
   assign str_off = rep[EV_LOPEN] || rep[EV_LSHORT] || trip[EV_SOPEN] ||
      ext_low || !ctrl_r[CTRL_EN_BIT];

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_hs_enable <= 1'b0;
         o_string_enable <= 1'b0;
      end else begin
         o_hs_enable <= !hs_off;
         o_string_enable <= !str_off;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // events: report rising edges and external pull-down
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         rep_d_r <= '0;
         ext_d_r <= 1'b0;
      end else begin
         rep_d_r <= rep;
         ext_d_r <= ext_low;
      end
   end
   assign ev = {ext_low && !ext_d_r, rep & ~rep_d_r};

   ////////////////////////////////////////////////////////////////////
   // wishbone classic slave, one wait state, ack for one cycle
   assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (i_wb_adr)
         ADR_CTRL: rd_nxt = {30'h0, ctrl_r};
         ADR_STAT: rd_nxt = {25'h0, stat_r};
         ADR_MASK: rd_nxt = {25'h0, mask_r};
         ADR_STATE: rd_nxt = {23'h0, !o_string_enable, !o_hs_enable,
            ext_low, rep};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= wb_req;
         o_wb_dat <= wb_req ? rd_nxt : 32'h0000_0000;
      end
   end

   // control and mask registers
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_r <= CTRL_RST;
         mask_r <= MASK_RST;
      end else if (wb_wr && i_wb_adr == ADR_CTRL) begin
         ctrl_r <= i_wb_dat[1:0];
      end else if (wb_wr && i_wb_adr == ADR_MASK) begin
         mask_r <= i_wb_dat[NUM_EV-1:0];
      end
   end

   // sticky status, write one to clear, a new event wins
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         stat_r <= '0;
      end else if (wb_wr && i_wb_adr == ADR_STAT) begin
         stat_r <= (stat_r & ~i_wb_dat[NUM_EV-1:0]) | ev;
      end else begin
         stat_r <= stat_r | ev;
      end
   end
   assign o_irq = |(stat_r & mask_r);

   ////////////////////////////////////////////////////////////////////
   // checks
   logic [9:0] open_run_r;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || !cond[EV_SOPEN]) begin
         open_run_r <= 10'h000;
      end else if (open_run_r != 10'h3ff) begin
         open_run_r <= open_run_r + 10'h001;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   ocp_off_a: assert property (cond[EV_OCP] |=> !o_hs_enable)
      else $error("switch not off after overcurrent");
   ocp_flag_a: assert property (cond[EV_OCP] |-> ##[1:3] o_fault_line_n_oe)
      else $error("fault line not driven after overcurrent");
   sopen_off_a: assert property (cond[EV_SOPEN] |=> !o_hs_enable && !o_string_enable)
      else $error("switch or string on with open sense");
   sopen_degl_a: assert property ($rose(rep[EV_SOPEN]) |->
      open_run_r >= 10'(DEGL_MIN))
      else $error("open sense flagged before deglitch");
   lopen_hold_a: assert property (rep[EV_LOPEN] |=> !o_string_enable)
      else $error("string on during led open");
   lopen_qual_a: assert property ($rose(rep[EV_LOPEN]) |-> $past(cond[EV_LOPEN], 2))
      else $error("led open flagged without condition");
   bopen_off_a: assert property (cond[EV_BOPEN] |=> !o_hs_enable)
      else $error("switch on with boot open");
   lock_off_a: assert property ($rose(cond[EV_BSHORT]) |=> !o_hs_enable [*2])
      else $error("switch on during lockout");
   ext_off_a: assert property (ext_low |=> !o_hs_enable && !o_string_enable)
      else $error("not disabled by external pull-down");
   line_drv_a: assert property (|rep |=> o_fault_line_n_oe && !o_fault_line_n_o)
      else $error("fault line released while reporting");

   ocp_seen_c: cover property ($rose(rep[EV_OCP]));
   short_seen_c: cover property ($fell(rep[EV_LSHORT]));
   ext_seen_c: cover property ($rose(ext_low));
   irq_seen_c: cover property ($rose(o_irq));

endmodule // lfs_supervisor
